// file: hdl/pwp_pkg.sv
// constants shared by the peripheral write-protection controller
`default_nettype none
package pwp_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;

    // ****************************************************************
    // register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [ADDR_W-1:0] PROTECT_CLEAR_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] PROTECT_SET_OFS   = 8'h04;
    localparam logic [DATA_W-1:0] PROTECT_RESET     = 32'h00000000;
    localparam logic [DATA_W-1:0] ZERO_WORD         = 32'h00000000;

    // ****************************************************************
    // instance selection
    // ****************************************************************
    localparam int unsigned INST_ZERO = 0;
    localparam int unsigned INST_ONE  = 1;
    localparam int unsigned INST_TWO  = 2;

    // ****************************************************************
    // slot positions, instance zero
    // ****************************************************************
    localparam int unsigned EXT_IRQ_CTRL_SLOT     = 6;
    localparam int unsigned REAL_TIME_CNT_SLOT    = 5;
    localparam int unsigned WATCHDOG_SLOT         = 4;
    localparam int unsigned GENERIC_CLOCK_SLOT    = 3;
    localparam int unsigned SYSTEM_CONTROL_SLOT   = 2;
    localparam int unsigned POWER_MANAGER_SLOT    = 1;

    // ****************************************************************
    // slot positions, instances one and two
    // ****************************************************************
    localparam int unsigned DEBUG_SERVICE_SLOT    = 1;
    localparam int unsigned ANALOG_CONV_SLOT      = 16;
    localparam int unsigned TIMER_COUNTER_SLOT_HI = 15;
    localparam int unsigned TIMER_COUNTER_SLOT_LO = 8;
    localparam int unsigned SERIAL_COMM_SLOT_HI   = 7;
    localparam int unsigned SERIAL_COMM_SLOT_LO   = 2;
    localparam int unsigned EVENT_SYSTEM_SLOT     = 1;

endpackage
`default_nettype wire

// file: hdl/peripheral_write_protect_ctrl.sv
// peripheral write-protection controller with set and clear registers
//
// How it works
// - clear register at 0x00 reads protection state
// - set register at 0x04 reads same state
// - zero written to clear changes nothing
// - one written to clear unprotects bit
// - all protection bits zero after reset
// - instance zero slots on bits six to one
// - instance one debug service slot bit one
// - instance two analog sixteen, timers fifteen-eight
// - instance two serial seven-two, events bit one
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module peripheral_write_protect_ctrl
    import pwp_pkg::*;
#(
    parameter int unsigned INSTANCE = INST_ZERO
) (
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [DATA_W-1:0] reg_rdata,
    input  wire logic [DATA_W-1:0] periph_wr_req,
    output var  logic [DATA_W-1:0] periph_wr_grant,
    output var  logic [DATA_W-1:0] periph_wr_blocked,
    output var  logic [DATA_W-1:0] protect_out
);

    // ****************************************************************
    // slot map per instance
    // ****************************************************************

    // one bit per implemented slot; unused bits stay zero forever
    function automatic logic [DATA_W-1:0] slot_mask(input int unsigned inst);
        logic [DATA_W-1:0] m;
        m = ZERO_WORD;
        if (inst == INST_ZERO) begin
            m[EXT_IRQ_CTRL_SLOT]   = 1'b1;
            m[REAL_TIME_CNT_SLOT]  = 1'b1;
            m[WATCHDOG_SLOT]       = 1'b1;
            m[GENERIC_CLOCK_SLOT]  = 1'b1;
            m[SYSTEM_CONTROL_SLOT] = 1'b1;
            m[POWER_MANAGER_SLOT]  = 1'b1;
        end else if (inst == INST_ONE) begin
            m[DEBUG_SERVICE_SLOT] = 1'b1;
        end else if (inst == INST_TWO) begin
            m[ANALOG_CONV_SLOT] = 1'b1;
            for (int i = TIMER_COUNTER_SLOT_LO; i <= TIMER_COUNTER_SLOT_HI; i++) begin
                m[i] = 1'b1;
            end
            for (int i = SERIAL_COMM_SLOT_LO; i <= SERIAL_COMM_SLOT_HI; i++) begin
                m[i] = 1'b1;
            end
            m[EVENT_SYSTEM_SLOT] = 1'b1;
        end
        return m;
    endfunction

    localparam logic [DATA_W-1:0] SLOT_MASK = slot_mask(INSTANCE);

    // ****************************************************************
    // address decode
    // ****************************************************************

    // strobes are one-cycle pulses that never meet, so no priority is
    // needed between a read and a write; the slave never stalls the master
    // and the read data always follow one cycle after the strobe
    logic              hit_clear;
    logic              hit_set;
    logic [DATA_W-1:0] protect_reg;
    logic [DATA_W-1:0] protect_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] grant_reg;
    logic [DATA_W-1:0] grant_next;
    logic [DATA_W-1:0] blocked_reg;
    logic [DATA_W-1:0] blocked_next;

    // partial decode is avoided so aliases never reach the state
    assign hit_clear = (reg_addr == PROTECT_CLEAR_OFS);
    assign hit_set   = (reg_addr == PROTECT_SET_OFS);

    // ****************************************************************
    // protection state, one slice per bit
    // ****************************************************************

    for (genvar b = 0; b < DATA_W; b++) begin : g_slot
        // write-one-to-clear and write-one-to-set on the same flop
        always_comb begin
            protect_next[b] = protect_reg[b];
            if (!SLOT_MASK[b]) begin
                protect_next[b] = 1'b0;
            end else if (reg_wr && hit_clear && reg_wdata[b]) begin
                protect_next[b] = 1'b0;
            end else if (reg_wr && hit_set && reg_wdata[b]) begin
                protect_next[b] = 1'b1;
            end
            // a zero data bit falls through and holds its state
        end
    end

    // state register, cleared to unprotected by reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            protect_reg <= PROTECT_RESET;
        end else begin
            protect_reg <= protect_next;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************

    // both offsets return the live state; unmapped reads give zero
    always_comb begin
        rdata_next = ZERO_WORD;
        if (reg_rd && hit_clear) begin
            rdata_next = protect_reg;
        end else if (reg_rd && hit_set) begin
            rdata_next = protect_reg;
        end
    end

    // read data holds only for the cycle after the strobe
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= ZERO_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // peripheral write gating
    // ****************************************************************

    // the gating result is registered, so a grant lags its request
    // by one cycle; the trade keeps every output straight off a flop
    always_comb begin
        grant_next   = periph_wr_req & ~protect_reg;
        blocked_next = periph_wr_req & protect_reg;
    end

    // grant and block registers, both quiet while in reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            grant_reg   <= ZERO_WORD;
            blocked_reg <= ZERO_WORD;
        end else begin
            grant_reg   <= grant_next;
            blocked_reg <= blocked_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // every output is a plain copy of a register, no logic after the flop
    assign reg_rdata         = rdata_reg;
    assign periph_wr_grant   = grant_reg;
    assign periph_wr_blocked = blocked_reg;
    assign protect_out       = protect_reg;

    // ****************************************************************
    // checks
    // ****************************************************************

    // all checks run on the one system clock and rest while in reset;
    // an attempt in flight when reset falls is dropped, not failed
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // helper: a clean write to either register in this cycle
    logic wr_clear;
    logic wr_set;
    assign wr_clear = reg_wr && hit_clear;
    assign wr_set   = reg_wr && hit_set;

    // a read of the clear offset returns the state seen with the strobe
    clear_read_back_a: assert property (
        reg_rd && hit_clear |=> reg_rdata == $past(protect_out))
        else $error("clear register read does not return state");

    // a read of the set offset returns the very same state
    set_read_back_a: assert property (
        reg_rd && hit_set |=> reg_rdata == $past(protect_out))
        else $error("set register read does not return state");

    // unmapped offsets read as zero
    unmapped_read_a: assert property (
        reg_rd && !hit_clear && !hit_set |=> reg_rdata == ZERO_WORD)
        else $error("unmapped read returned nonzero data");

    // zero bits of a clear write keep their slots as they were
    clear_zero_hold_a: assert property (
        wr_clear |=> (protect_out & ~$past(reg_wdata))
                  == ($past(protect_out) & ~$past(reg_wdata)))
        else $error("zero bit in clear write changed state");

    // one bits of a clear write leave their slots unprotected
    clear_one_bit_a: assert property (
        wr_clear |=> (protect_out & $past(reg_wdata)) == ZERO_WORD)
        else $error("clear write left a bit protected");

    // the first edge after release still shows the reset state
    reset_state_a: assert property (
        $rose(arst_n) |-> protect_out == PROTECT_RESET)
        else $error("protection not cleared by reset");

    // slots outside this instance's map can never be protected
    unused_bits_a: assert property (
        (protect_out & ~SLOT_MASK) == ZERO_WORD)
        else $error("unimplemented slot became protected");

    // one bits of a set write protect every mapped slot they name
    set_one_bit_a: assert property (
        wr_set |=> (protect_out & $past(reg_wdata))
                == ($past(reg_wdata) & SLOT_MASK))
        else $error("set write did not protect the slot");

    // zero bits of a set write keep their slots as they were
    set_zero_hold_a: assert property (
        wr_set |=> (protect_out & ~$past(reg_wdata))
                == ($past(protect_out) & ~$past(reg_wdata)))
        else $error("zero bit in set write changed state");

    // with no write for two cycles running the state does not move
    idle_state_hold_a: assert property (
        !reg_wr ##1 !reg_wr |=> $stable(protect_out))
        else $error("state changed without a write");

    // a protected slot gets no grant and shows a block instead
    block_when_set_a: assert property (
        1'b1 |=> (periph_wr_grant & $past(protect_out)) == ZERO_WORD
              && periph_wr_blocked == ($past(periph_wr_req) & $past(protect_out)))
        else $error("write passed to a protected slot");

    // an unprotected slot is granted one cycle after its request
    grant_when_clear_a: assert property (
        1'b1 |=> periph_wr_grant == ($past(periph_wr_req) & ~$past(protect_out)))
        else $error("write to an unprotected slot was dropped");

    // writes to an unmapped address leave the state alone
    unmapped_write_a: assert property (
        reg_wr && !hit_clear && !hit_set |=> $stable(protect_out))
        else $error("unmapped write changed the state");

    // a clear write can only lower bits, never raise one
    clear_never_sets_a: assert property (
        wr_clear |=> (protect_out & ~$past(protect_out)) == ZERO_WORD)
        else $error("clear write raised a protection bit");

    // a set write can only raise bits, never lower one
    set_never_clears_a: assert property (
        wr_set |=> ($past(protect_out) & ~protect_out) == ZERO_WORD)
        else $error("set write lowered a protection bit");

    // reading the state must not disturb it
    read_keeps_state_a: assert property (
        reg_rd && !reg_wr |=> $stable(protect_out))
        else $error("read strobe changed the state");

    // read data stand for one cycle only, then fall back to zero
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == ZERO_WORD)
        else $error("read data shown without a read strobe");

    // every request comes back as exactly a grant or a block
    grant_block_split_a: assert property (
        1'b1 |=> (periph_wr_grant | periph_wr_blocked)
              == $past(periph_wr_req))
        else $error("peripheral request lost or invented");

    // no slot is granted and blocked at once
    grant_block_apart_a: assert property (
        (periph_wr_grant & periph_wr_blocked) == ZERO_WORD)
        else $error("slot both granted and blocked");

    // slots outside the map are never blocked
    unused_never_blocked_a: assert property (
        (periph_wr_blocked & ~SLOT_MASK) == ZERO_WORD)
        else $error("unmapped slot was blocked");

    // bus and gate outputs come out of reset quiet
    reset_outputs_a: assert property (
        $rose(arst_n) |-> reg_rdata == ZERO_WORD
                       && periph_wr_grant == ZERO_WORD
                       && periph_wr_blocked == ZERO_WORD)
        else $error("outputs not quiet after reset");

    // requests on unmapped slots always pass through as grants
    unused_slot_pass_a: assert property (
        1'b1 |=> (periph_wr_grant & ~SLOT_MASK)
              == ($past(periph_wr_req) & ~SLOT_MASK))
        else $error("unmapped slot request was not granted");

endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking testbench for the peripheral write-protection controller
`timescale 1ns/10ps
`default_nettype none
module testbench
    import pwp_pkg::*;
;
    typedef struct {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] exp [3];
    } row_t;

    logic              clk_sys;
    logic              arst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] periph_wr_req;
    logic [DATA_W-1:0] rdata   [3];
    logic [DATA_W-1:0] grant   [3];
    logic [DATA_W-1:0] blocked [3];
    logic [DATA_W-1:0] prot    [3];
    logic [DATA_W-1:0] zeros   [3] = '{ZERO_WORD, ZERO_WORD, ZERO_WORD};
    int                failures;
    int                samples_checked;
    int                cycles;
    // expected state of instances zero, one and two after each write
    row_t              rows    [8] = '{
        '{8'h04, 32'hFFFFFFFF, '{32'h0000007E, 32'h00000002, 32'h0001FFFE}},
        '{8'h00, 32'h00000000, '{32'h0000007E, 32'h00000002, 32'h0001FFFE}},
        '{8'h00, 32'h00000010, '{32'h0000006E, 32'h00000002, 32'h0001FFEE}},
        '{8'h04, 32'h00000000, '{32'h0000006E, 32'h00000002, 32'h0001FFEE}},
        '{8'h08, 32'hFFFFFFFF, '{32'h0000006E, 32'h00000002, 32'h0001FFEE}},
        '{8'h00, 32'hFFFFFFFF, '{32'h00000000, 32'h00000000, 32'h00000000}},
        '{8'h04, 32'h00010042, '{32'h00000042, 32'h00000002, 32'h00010042}},
        '{8'h04, 32'h0000FF04, '{32'h00000046, 32'h00000002, 32'h0001FF46}}
    };

    // one controller per slot map, all on the same register bus
    for (genvar g = 0; g < 3; g++) begin : gen_inst
        peripheral_write_protect_ctrl #(
            .INSTANCE (g)
        ) peripheral_write_protect_ctrl_i (
            .clk_sys           (clk_sys),
            .arst_n            (arst_n),
            .reg_addr          (reg_addr),
            .reg_wdata         (reg_wdata),
            .reg_wr            (reg_wr),
            .reg_rd            (reg_rd),
            .reg_rdata         (rdata[g]),
            .periph_wr_req     (periph_wr_req),
            .periph_wr_grant   (grant[g]),
            .periph_wr_blocked (blocked[g]),
            .protect_out       (prot[g])
        );
    end

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // *****************************************************************
    // bus tasks and comparisons
    // *****************************************************************
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // strobes rise on an edge and drop on the taking edge; one edge passes between calls
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so look there
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e [3]);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        for (int i = 0; i < 3; i++) chk("reg_rdata", e[i], rdata[i]);
    endtask

    task automatic chk_prot(input logic [DATA_W-1:0] e [3]);
        for (int i = 0; i < 3; i++) chk("protect_out", e[i], prot[i]);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a hang costs a mismatch and ends the run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            report_and_stop();
        end
    end

    // *****************************************************************
    // main sequence
    // *****************************************************************
    initial begin
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        periph_wr_req = 32'h00000000;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        chk_prot(zeros);
        rd(PROTECT_CLEAR_OFS, zeros);
        for (int r = 0; r < 8; r++) begin
            wr(rows[r].addr, rows[r].data);
            chk_prot(rows[r].exp);
            rd(PROTECT_CLEAR_OFS, rows[r].exp);
            rd(PROTECT_SET_OFS, rows[r].exp);
        end
        // unmapped read gives zero, and read data fall back to zero afterwards
        rd(8'h08, zeros);
        rd(PROTECT_SET_OFS, rows[7].exp);
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 3; i++) chk("idle reg_rdata", ZERO_WORD, rdata[i]);
        // every slot tries a write; protected ones must be held off
        @(posedge clk_sys);
        periph_wr_req <= 32'hFFFFFFFF;
        @(posedge clk_sys);
        periph_wr_req <= 32'h00000000;
        #1;
        for (int i = 0; i < 3; i++) chk("grant", ~rows[7].exp[i], grant[i]);
        for (int i = 0; i < 3; i++) chk("blocked", rows[7].exp[i], blocked[i]);
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 3; i++) chk("late grant", ZERO_WORD, grant[i]);
        // second reset in mid-run wipes protection at once
        arst_n <= 1'b0;
        #1;
        chk_prot(zeros);
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        rd(PROTECT_SET_OFS, zeros);
        report_and_stop();
    end
endmodule
`default_nettype wire
